// ==== cmp_counter.sv ====
`timescale 1ns/100ps
module cmp_counter
  import cmp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic [1:0] wave_mode,
  input wire logic [7:0] cmp_active,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  cmp_event_if.src ev
);
  logic [7:0] cnt_q;
  logic block_q;

  assign ev.count = cnt_q;
  // A counter write masks the match in the following timer cycle
  assign ev.match = (cnt_q == cmp_active) && !block_q;
  assign ev.bottom = (cnt_q == CNT_BOTTOM);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= CNT_BOTTOM;
    end else if (cnt_wr) begin
      cnt_q <= cnt_wdata; // R21
    end else if (tick) begin
      if (wave_mode == WAVE_CLEAR_ON_MATCH && cnt_q == cmp_active) begin
        cnt_q <= CNT_BOTTOM; // R11 R12
      end else begin
        cnt_q <= cnt_q + 8'h00_01; // R7 R8 R15 R18
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      block_q <= 1'b0;
    end else if (cnt_wr) begin
      block_q <= 1'b1;
    end else if (tick) begin
      block_q <= 1'b0;
    end
  end

  property p_wrap;
    @(posedge mclk) disable iff (!arst_n)
    (tick && !cnt_wr && wave_mode == WAVE_NORMAL && cnt_q == CNT_MAX)
      |=> cnt_q == CNT_BOTTOM;
  endproperty
  a_wrap: assert property (p_wrap) else $error("normal mode did not wrap"); // R8

  property p_step;
    @(posedge mclk) disable iff (!arst_n)
    (tick && !cnt_wr && wave_mode == WAVE_NORMAL && cnt_q != CNT_MAX)
      |=> cnt_q == $past(cnt_q) + 8'h00_01;
  endproperty
  a_step: assert property (p_step) else $error("normal mode did not count up"); // R7

  property p_cwr;
    @(posedge mclk) disable iff (!arst_n)
    cnt_wr |=> cnt_q == $past(cnt_wdata);
  endproperty
  a_cwr: assert property (p_cwr) else $error("counter write lost"); // R21

  property p_blk;
    @(posedge mclk) disable iff (!arst_n)
    cnt_wr |=> !ev.match;
  endproperty
  a_blk: assert property (p_blk) else $error("match not masked after write"); // R12
endmodule : cmp_counter

// ==== cmp_event_if.sv ====
`timescale 1ns/100ps
// Counter events handed from the counter to the output stage
interface cmp_event_if;
  logic match;
  logic bottom;
  logic [7:0] count;
  modport src (output match, output bottom, output count);
  modport dst (input match, input bottom, input count);
endinterface : cmp_event_if

// ==== cmp_pkg.sv ====
// What this block does
// R1: Nonzero output mode routes compare state to pin
// R2: Pin direction still follows port direction bit
// R3: Override ignores waveform mode
// R4: Compare state settable while pin disabled
// R5: Output mode zero leaves state unchanged
// R6: New mode acts next match; force acts now
// R7: Counting depends only on waveform mode
// R8: Normal mode counts up, wraps 0xFF to 0x00
// R9: Normal overflow set when counter becomes zero
// R10: Overflow cleared when its interrupt serviced
// R11: Clear-on-match clears counter at compare value
// R12: No buffering; missed match wraps through 0xFF
// R13: Clear-on-match mode 1 toggles every match
// R14: Clear-on-match overflow set passing max to zero; code does not set it when a match clears the counter at 0xFF
// R15: Fast PWM counts zero to max, then clears
// R16: Fast PWM mode 2 non-inverting, 3 inverting
// R17: Fast PWM overflow set at max
// R18: Fast PWM period is 256 timer clocks
// R19: Compare zero spikes; compare max gives constant
// R20: Fast PWM mode 1 toggles, value still buffered
// R21: Software may write counter any time
// R22: Non-PWM modes: 1 toggle, 2 clear, 3 set
// R23: Match sets compare flag next cycle; write-one clears
// R24: PWM buffers compare value, loads at top
// R25: Reset: state low, mode fields zero
package cmp_pkg;
  localparam int CNT_W = 8;
  localparam logic [7:0] CNT_MAX = 8'h00_FF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00_00;
  localparam logic [1:0] WAVE_NORMAL = 2'h0_0;
  localparam logic [1:0] WAVE_PHASE = 2'h0_1;
  localparam logic [1:0] WAVE_CLEAR_ON_MATCH = 2'h0_2;
  localparam logic [1:0] WAVE_FAST_PWM = 2'h0_3;
  localparam logic [1:0] OUT_OFF = 2'h0_0;
  localparam logic [1:0] OUT_TOGGLE = 2'h0_1;
  localparam logic [1:0] OUT_CLEAR = 2'h0_2;
  localparam logic [1:0] OUT_SET = 2'h0_3;
  localparam logic [1:0] MODE_RESET = 2'h0_0;
  localparam logic OUT_RESET = 1'b0;
  typedef enum logic [1:0] {ACT_NONE, ACT_TOGGLE, ACT_CLEAR, ACT_SET} out_act_e;
endpackage : cmp_pkg

// ==== cmp_timer.sv ====
`timescale 1ns/100ps
module cmp_timer
  import cmp_pkg::*;
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic tick,
  input wire logic [1:0] wave_mode_in,
  input wire logic [1:0] compare_output_mode_in,
  input wire logic mode_wr,
  input wire logic [7:0] compare_value,
  input wire logic cmp_wr,
  input wire logic cnt_wr,
  input wire logic [7:0] cnt_wdata,
  input wire logic force_compare_strobe,
  input wire logic ovf_ack,
  input wire logic cmp_flag_clr,
  input wire logic port_out,
  input wire logic compare_pin_direction_bit,
  output logic [7:0] counter_value,
  output logic overflow_flag,
  output logic compare_flag,
  output logic compare_output,
  output logic pin_out,
  output logic pin_oe
);
  import cmp_pkg::*;

  logic [1:0] wave_q;
  logic [1:0] com_q;
  logic [7:0] cmp_buf_q;
  logic [7:0] cmp_act_q;
  logic oc_q;
  logic ovf_q;
  logic ocf_q;
  logic match_pend_q;
  logic pwm;
  logic top;
  out_act_e act;
  cmp_event_if ev ();

  cmp_counter u_cnt (
    .mclk(mclk),
    .arst_n(arst_n),
    .tick(tick),
    .wave_mode(wave_q),
    .cmp_active(cmp_act_q),
    .cnt_wr(cnt_wr),
    .cnt_wdata(cnt_wdata),
    .ev(ev.src)
  );

  assign pwm = wave_q[0];
  assign top = (ev.count == CNT_MAX);

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wave_q <= MODE_RESET; // R25
      com_q <= MODE_RESET;
    end else if (mode_wr) begin
      wave_q <= wave_mode_in;
      com_q <= compare_output_mode_in; // R6
    end
  end

  // Buffered in PWM modes, transparent otherwise
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_buf_q <= CNT_BOTTOM;
    end else if (cmp_wr) begin
      cmp_buf_q <= compare_value;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmp_act_q <= CNT_BOTTOM;
    end else if (cmp_wr && !pwm) begin
      cmp_act_q <= compare_value; // R24 R12
    end else if (pwm && tick && top) begin
      cmp_act_q <= cmp_buf_q; // R24 R20
    end
  end

  always_comb begin
    act = ACT_NONE;
    case (com_q)
      OUT_TOGGLE: act = ACT_TOGGLE; // R13 R20 R22
      OUT_CLEAR: act = ACT_CLEAR;
      OUT_SET: act = ACT_SET;
      default: act = ACT_NONE; // R5
    endcase
  end

  // Fast PWM: match wins over top so compare max yields a constant level
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      oc_q <= OUT_RESET; // R25
    end else if (!pwm && force_compare_strobe) begin
      case (act)
        ACT_TOGGLE: oc_q <= !oc_q; // R4 R6
        ACT_CLEAR: oc_q <= 1'b0;
        ACT_SET: oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end else if (tick && ev.match) begin
      case (act)
        ACT_TOGGLE: oc_q <= !oc_q;
        ACT_CLEAR: oc_q <= 1'b0; // R16 R22
        ACT_SET: oc_q <= 1'b1;
        default: oc_q <= oc_q;
      endcase
    end else if (tick && wave_q == WAVE_FAST_PWM && top) begin
      // Next cycle is bottom; level set for the new period
      if (act == ACT_CLEAR && cmp_buf_q != CNT_MAX) begin
        oc_q <= 1'b1; // R16 R19
      end else if (act == ACT_SET && cmp_buf_q != CNT_MAX) begin
        oc_q <= 1'b0;
      end
    end
  end

  // Overflow: set on max to zero, except when a clear-on-match match clears the counter at max
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ovf_q <= 1'b0;
    end else if (tick && !cnt_wr && top && !(wave_q == WAVE_CLEAR_ON_MATCH && ev.match)) begin
      ovf_q <= 1'b1; // R9 R14 R17
    end else if (ovf_ack) begin
      ovf_q <= 1'b0; // R10
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      match_pend_q <= 1'b0;
    end else begin
      match_pend_q <= tick && ev.match;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ocf_q <= 1'b0;
    end else if (match_pend_q) begin
      ocf_q <= 1'b1; // R23
    end else if (cmp_flag_clr) begin
      ocf_q <= 1'b0;
    end
  end

  assign counter_value = ev.count;
  assign overflow_flag = ovf_q;
  assign compare_flag = ocf_q;
  assign compare_output = oc_q;
  assign pin_out = (com_q != OUT_OFF) ? oc_q : port_out; // R1 R3
  assign pin_oe = compare_pin_direction_bit; // R2

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!arst_n);

  property p_ovr;
    (com_q != OUT_OFF) |-> pin_out == oc_q;
  endproperty
  a_ovr: assert property (p_ovr) else $error("override missing"); // R1
  property p_port;
    (com_q == OUT_OFF) |-> pin_out == port_out;
  endproperty
  a_port: assert property (p_port) else $error("port data not passed"); // R1
  property p_dir;
    pin_oe == compare_pin_direction_bit;
  endproperty
  a_dir: assert property (p_dir) else $error("direction"); // R2
  property p_hold;
    (com_q == OUT_OFF && !mode_wr) |=> $stable(oc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("mode zero changed output"); // R5
  property p_flag;
    (tick && ev.match) |-> ##2 ocf_q;
  endproperty
  a_flag: assert property (p_flag) else $error("compare flag late"); // R23
  property p_fclr;
    (cmp_flag_clr && !match_pend_q) |=> !ocf_q;
  endproperty
  a_fclr: assert property (p_fclr) else $error("compare flag not cleared"); // R23
  property p_ovf;
    (tick && !cnt_wr && top && wave_q != WAVE_CLEAR_ON_MATCH) |=> ovf_q;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not set"); // R9
  property p_tog;
    (tick && ev.match && com_q == OUT_TOGGLE && !force_compare_strobe && !mode_wr)
      |=> oc_q != $past(oc_q);
  endproperty
  a_tog: assert property (p_tog) else $error("no toggle"); // R13
  property p_clr;
    (tick && !cnt_wr && wave_q == WAVE_CLEAR_ON_MATCH && ev.count == cmp_act_q)
      |=> ev.count == CNT_BOTTOM;
  endproperty
  a_clr: assert property (p_clr) else $error("no clear"); // R11
  property p_frc;
    (!pwm && force_compare_strobe && com_q == OUT_SET && !mode_wr) |=> oc_q;
  endproperty
  a_frc: assert property (p_frc) else $error("force failed"); // R6
  property p_nofrc;
    (pwm && force_compare_strobe && !tick) |=> $stable(oc_q);
  endproperty
  a_nofrc: assert property (p_nofrc) else $error("force acted in pwm mode"); // R6
  property p_bot;
    (tick && wave_q == WAVE_FAST_PWM && top && !ev.match && com_q == OUT_CLEAR
      && cmp_buf_q != CNT_MAX) |=> oc_q;
  endproperty
  a_bot: assert property (p_bot) else $error("pwm output not set at bottom"); // R16
  property p_direct;
    (cmp_wr && !pwm) |=> cmp_act_q == $past(compare_value);
  endproperty
  a_direct: assert property (p_direct) else $error("compare value not immediate"); // R24
  property p_wave;
    mode_wr |=> wave_q == $past(wave_mode_in);
  endproperty
  a_wave: assert property (p_wave) else $error("waveform mode not loaded"); // R7
endmodule : cmp_timer

// ==== pin_pad_model.sv ====
`timescale 1ns/100ps
// Port pin with a weak pull-up, seen from outside the device
module pin_pad_model (
  input wire logic pin_out,
  input wire logic pin_oe,
  output wire logic pad
);
  // Released pin floats to the pull-up level, never the last driven value
  assign pad = pin_oe ? pin_out : 1'b1;
endmodule : pin_pad_model

// ==== tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
  import cmp_pkg::*;
  logic mclk = 0, arst_n = 0, tick = 0, mode_wr = 0, cmp_wr = 0, cnt_wr = 0;
  logic [1:0] wave = 0, com = 0;
  logic [7:0] cval = 0, cdat = 0, cnt;
  logic force_s = 0, ovf_ack = 0, fclr = 0, port_out = 0, dir = 0;
  logic ovf, cflag, cout, pout, poe;
  wire logic pad;
  int bad_count = 0, n_tests = 0, hi, i;
  logic [7:0] pv [2] = '{8'h00_80, 8'h00_00};
  always #20 mclk = ~mclk;
  cmp_timer dut (.mclk(mclk), .arst_n(arst_n), .tick(tick), .wave_mode_in(wave),
    .compare_output_mode_in(com), .mode_wr(mode_wr), .compare_value(cval),
    .cmp_wr(cmp_wr), .cnt_wr(cnt_wr), .cnt_wdata(cdat), .force_compare_strobe(force_s),
    .ovf_ack(ovf_ack), .cmp_flag_clr(fclr), .port_out(port_out),
    .compare_pin_direction_bit(dir), .counter_value(cnt), .overflow_flag(ovf),
    .compare_flag(cflag), .compare_output(cout), .pin_out(pout), .pin_oe(poe));
  pin_pad_model pin (.pin_out(pout), .pin_oe(poe), .pad(pad));
  task conclude;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task set_mode(input logic [1:0] w, input logic [1:0] c);
    @(negedge mclk); wave = w; com = c; mode_wr = 1;
    @(negedge mclk); mode_wr = 0;
  endtask : set_mode
  task wr_val(input logic is_cnt, input logic [7:0] v);
    @(negedge mclk); cval = v; cdat = v; cmp_wr = !is_cnt; cnt_wr = is_cnt;
    @(negedge mclk); cmp_wr = 0; cnt_wr = 0;
  endtask : wr_val
  // 0 force, 1 overflow ack, 2 compare flag clear
  task strobe(input int k);
    @(negedge mclk); force_s = (k == 0); ovf_ack = (k == 1); fclr = (k == 2);
    @(negedge mclk); force_s = 0; ovf_ack = 0; fclr = 0;
  endtask : strobe
  task ticks(input int n);
    @(negedge mclk); tick = 1;
    repeat (n) @(negedge mclk);
    tick = 0;
  endtask : ticks
  // Counts high cycles over one whole period, starting at bottom
  task pwm_hi;
    for (i = 0; i < 300 && cnt !== 8'h00_00; i++) @(negedge mclk);
    hi = 0;
    repeat (256) begin
      hi += (cout === 1'b1);
      @(negedge mclk);
    end
  endtask : pwm_hi
  initial begin
    #(40 * 8000);
    bad_count++;
    conclude();
  end
  initial begin
    repeat (6) @(negedge mclk);
    chk("rst cout", cout, 0);
    chk("rst cnt", cnt, 0);
    arst_n = 1;
    set_mode(WAVE_NORMAL, OUT_CLEAR);
    strobe(0);
    chk("clr cout", cout, 0);
    chk("pad off", pad, 1);
    set_mode(WAVE_NORMAL, OUT_TOGGLE);
    strobe(0);
    chk("tgl cout", cout, 1);
    strobe(0);
    chk("tgl2 cout", cout, 0);
    set_mode(WAVE_NORMAL, OUT_OFF);
    strobe(0);
    chk("off cout", cout, 0);
    set_mode(WAVE_NORMAL, OUT_SET);
    strobe(0);
    chk("set cout", cout, 1);
    dir = 1;
    @(negedge mclk);
    chk("ovr pin", pout, 1);
    chk("ovr oe", poe, 1);
    set_mode(WAVE_FAST_PWM, OUT_CLEAR);
    strobe(0);
    chk("pwm force", cout, 1);
    chk("pwm ovr", pout, 1);
    set_mode(WAVE_NORMAL, OUT_OFF);
    chk("port pin", pout, 0);
    wr_val(1, 8'h00_FE);
    ticks(1);
    chk("ovf early", ovf, 0);
    ticks(1);
    chk("wrap", cnt, 8'h00_00);
    chk("ovf", ovf, 1);
    strobe(1);
    chk("ovf ack", ovf, 0);
    set_mode(WAVE_CLEAR_ON_MATCH, OUT_TOGGLE);
    wr_val(0, 8'h00_03);
    wr_val(1, 8'h00_00);
    for (int k = 1; k <= 3; k++) begin
      ticks(1);
      chk("ctc cnt", cnt, k[7:0]);
    end
    ticks(1);
    chk("ctc top", cnt, 8'h00_00);
    chk("ctc tgl", cout, 0);
    repeat (2) @(negedge mclk);
    chk("cflag", cflag, 1);
    strobe(2);
    chk("cflag clr", cflag, 0);
    chk("ctc ovf", ovf, 0);
    wr_val(1, 8'h00_05);
    ticks(250);
    chk("miss", cnt, 8'h00_FF);
    ticks(1);
    chk("miss wrap", cnt, 8'h00_00);
    chk("ctc ovf", ovf, 1);
    strobe(1);
    for (int m = 0; m < 4; m++) begin
      set_mode(WAVE_FAST_PWM, m[0] ? OUT_SET : OUT_CLEAR);
      wr_val(0, pv[m / 2]);
      @(negedge mclk); tick = 1;
      repeat (300) @(negedge mclk);
      pwm_hi();
      chk("pwm high", hi[7:0], m[0] ? 8'h00_FF - pv[m / 2] : pv[m / 2] + 1);
      chk("pwm ovf", ovf, 1);
      tick = 0;
    end
    conclude();
  end
endmodule : tb_top
